// *** ltim_pkg.sv ***
// Constants, register indices and state types of the dual timebase timer with capture.
package ltim_pkg;

    // Prescaler: both counters advance once every 32 clock cycles.
    localparam int         LTIM_PRESCALE       = 32;
    localparam logic [4:0] LTIM_PRESCALE_LAST  = 5'(LTIM_PRESCALE - 1);

    // First timebase period in oscillator periods; the doubled period is twice this.
    localparam int         LTIM_TB1_PERIOD_OSC = 8000;
    localparam logic [7:0] LTIM_TB1_WRAP       = 8'(LTIM_TB1_PERIOD_OSC / LTIM_PRESCALE - 1);
    localparam logic [7:0] LTIM_CNT2_TOP       = 8'hFF;

    // Register indices; the byte address on APB is four times the index.
    localparam logic [5:0] LTIM_IDX_CTRL2      = 6'h08;
    localparam logic [5:0] LTIM_IDX_RELOAD     = 6'h09;
    localparam logic [5:0] LTIM_IDX_COUNT2     = 6'h0A;
    localparam logic [5:0] LTIM_IDX_CTRL1      = 6'h0B;
    localparam logic [5:0] LTIM_IDX_CAPTURE    = 6'h0C;
    localparam logic [5:0] LTIM_IDX_IRQ_STATUS = 6'h0D;
    localparam logic [5:0] LTIM_IDX_IRQ_MASK   = 6'h0E;

    // Bit positions in the two control/status registers.
    localparam int LTIM_CTRL2_OVF2_IE   = 1;
    localparam int LTIM_CTRL2_OVF2_FLAG = 0;
    localparam int LTIM_CTRL1_CAP_IE    = 7;
    localparam int LTIM_CTRL1_CAP_FLAG  = 6;
    localparam int LTIM_CTRL1_PERIOD    = 5;
    localparam int LTIM_CTRL1_OVF1_IE   = 4;
    localparam int LTIM_CTRL1_OVF1_FLAG = 3;

    // Bit positions in the sticky interrupt status and mask registers.
    localparam int LTIM_IRQ_W    = 3;
    localparam int LTIM_IRQ_OVF1 = 0;
    localparam int LTIM_IRQ_OVF2 = 1;
    localparam int LTIM_IRQ_CAP  = 2;

    localparam logic [23:0] LTIM_RDATA_PAD = 24'h000000;
    localparam logic [7:0]  LTIM_BYTE_ZERO = 8'h00;

    // APB request from the master.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ltim_apb_req_type;

    // Whole state of the timer.
    typedef struct packed {
        logic [4:0]            prescale;
        logic [7:0]            count1;
        logic                  tb1_half;
        logic [7:0]            count2;
        logic [7:0]            reload;
        logic [7:0]            capture;
        logic                  ovf2_irq_enable;
        logic                  ovf2_flag;
        logic                  cap_irq_enable;
        logic                  cap_flag;
        logic                  period_double;
        logic                  ovf1_irq_enable;
        logic                  ovf1_flag;
        logic [LTIM_IRQ_W-1:0] irq_status;
        logic [LTIM_IRQ_W-1:0] irq_mask;
        logic                  pin_meta;
        logic                  pin_sync;
        logic                  pin_prev;
        logic [31:0]           prdata;
    } ltim_state_type;

    localparam ltim_state_type LTIM_STATE_RST = '0;

endpackage

// *** ltim_top.sv ***
// Dual timebase timer with input capture, reached over an APB slave port.
//
// How it works
// - Second enable gates counter2 overflow request.
// - Second flag set on overflow, read clears.
// - Reload value copied into counter2 at overflow.
// - Counter2 register reads live count, resets zero.
// - First control register resets to all zero.
// - Capture enable gates capture interrupt request.
// - Capture flag set by capture, capture read clears.
// - Period select doubles first timebase period.
// - First enable gates counter1 overflow request.
// - First flag set on overflow, read clears.
// - Edge latches counter1 unless capture flag set.
// - Counter1 counts at clock/32, wraps F9h to 00h.
// - Counter2 counts at clock/32, reloads after FFh.
// - Halt stops both counters and the prescaler.
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module ltim_top
    import ltim_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire ltim_apb_req_type apb_req,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             halt_mode,
    input  wire logic             capture_pin,
    output logic                  irq_first_overflow,
    output logic                  irq_second_overflow,
    output logic                  irq_capture,
    output logic                  irq
);

    ltim_state_type        cur;
    ltim_state_type        next_state;
    logic                  tick;
    logic                  ovf1_wrap;
    logic                  ovf1_ev;
    logic                  ovf2_ev;
    logic                  pin_edge;
    logic                  cap_ev;
    logic                  access;
    logic                  hit;
    logic                  rd;
    logic                  wr;
    logic [5:0]            idx;
    logic [7:0]            rbyte;
    logic [7:0]            wbyte;
    logic [LTIM_IRQ_W-1:0] events;

    // Index decode of a byte address; the two low bits must be zero.
    function automatic logic [5:0] reg_index(input logic [7:0] addr);
        reg_index = addr[7:2];
    endfunction

    // An address hits a register only when aligned and inside the map.
    function automatic logic reg_hit(input logic [7:0] addr);
        logic [5:0] i;
        i = reg_index(addr);
        reg_hit = (addr[1:0] == 2'h0) && (i >= LTIM_IDX_CTRL2) && (i <= LTIM_IDX_IRQ_MASK);
    endfunction

    // Bus decode; an access is a completed APB transfer since pready is always high.
    assign idx    = reg_index(apb_req.paddr);
    assign hit    = reg_hit(apb_req.paddr);
    assign access = apb_req.psel && apb_req.penable;
    assign rd     = access && !apb_req.pwrite && hit;
    assign wr     = access && apb_req.pwrite && hit;
    assign wbyte  = apb_req.pwdata[7:0];

    // Timebase events. Halt freezes the prescaler, so no tick ever appears in halt.
    assign tick      = !halt_mode && (cur.prescale == LTIM_PRESCALE_LAST);
    assign ovf1_wrap = tick && (cur.count1 == LTIM_TB1_WRAP);
    assign ovf1_ev   = ovf1_wrap && (!cur.period_double || cur.tb1_half);
    assign ovf2_ev   = tick && (cur.count2 == LTIM_CNT2_TOP);

    // Edge detection looks only at the second and third stages, never the first.
    assign pin_edge = cur.pin_sync ^ cur.pin_prev;
    assign cap_ev   = pin_edge && !cur.cap_flag;

    assign events[LTIM_IRQ_OVF1] = ovf1_ev;
    assign events[LTIM_IRQ_OVF2] = ovf2_ev;
    assign events[LTIM_IRQ_CAP]  = cap_ev;

    // Read multiplexer; reserved bits and unmapped indices read as zero.
    always_comb begin
        rbyte = LTIM_BYTE_ZERO;
        case (idx)
            LTIM_IDX_CTRL2: begin
                rbyte[LTIM_CTRL2_OVF2_IE]   = cur.ovf2_irq_enable;
                rbyte[LTIM_CTRL2_OVF2_FLAG] = cur.ovf2_flag;
            end
            LTIM_IDX_RELOAD: begin
                rbyte = cur.reload;
            end
            LTIM_IDX_COUNT2: begin
                rbyte = cur.count2;
            end
            LTIM_IDX_CTRL1: begin
                rbyte[LTIM_CTRL1_CAP_IE]    = cur.cap_irq_enable;
                rbyte[LTIM_CTRL1_CAP_FLAG]  = cur.cap_flag;
                rbyte[LTIM_CTRL1_PERIOD]    = cur.period_double;
                rbyte[LTIM_CTRL1_OVF1_IE]   = cur.ovf1_irq_enable;
                rbyte[LTIM_CTRL1_OVF1_FLAG] = cur.ovf1_flag;
            end
            LTIM_IDX_CAPTURE: begin
                rbyte = cur.capture;
            end
            LTIM_IDX_IRQ_STATUS: begin
                rbyte[LTIM_IRQ_W-1:0] = cur.irq_status;
            end
            LTIM_IDX_IRQ_MASK: begin
                rbyte[LTIM_IRQ_W-1:0] = cur.irq_mask;
            end
            default: begin
                rbyte = LTIM_BYTE_ZERO;
            end
        endcase
    end

    // Next-state logic for the whole block.
    always_comb begin
        next_state = cur;

        // Prescaler advances unless halted; five bits wrap naturally at 32.
        if (!halt_mode) begin
            next_state.prescale = cur.prescale + 5'h01;
        end

        // Counter1 and its wrap phase, which picks every second wrap when doubled.
        if (tick) begin
            if (ovf1_wrap) begin
                next_state.count1   = LTIM_BYTE_ZERO;
                next_state.tb1_half = !cur.tb1_half;
            end else begin
                next_state.count1 = cur.count1 + 8'h01;
            end
        end

        // Counter2 reloads from the reload register instead of rolling to zero.
        if (ovf2_ev) begin
            next_state.count2 = cur.reload;
        end else if (tick) begin
            next_state.count2 = cur.count2 + 8'h01;
        end

        // Clearing reads come first so that a same-cycle event overrides them.
        if (rd && (idx == LTIM_IDX_CTRL2)) begin
            next_state.ovf2_flag = 1'b0;
        end
        if (rd && (idx == LTIM_IDX_CTRL1)) begin
            next_state.ovf1_flag = 1'b0;
        end
        if (rd && (idx == LTIM_IDX_CAPTURE)) begin
            next_state.cap_flag = 1'b0;
        end
        if (rd && (idx == LTIM_IDX_IRQ_STATUS)) begin
            next_state.irq_status = '0;
        end

        // Hardware sets win over the clears above.
        if (ovf2_ev) begin
            next_state.ovf2_flag = 1'b1;
        end
        if (ovf1_ev) begin
            next_state.ovf1_flag = 1'b1;
        end
        if (cap_ev) begin
            next_state.capture  = cur.count1;
            next_state.cap_flag = 1'b1;
        end
        next_state.irq_status = next_state.irq_status | events;

        // Register writes; flags and read-only registers ignore write data.
        if (wr) begin
            case (idx)
                LTIM_IDX_CTRL2: begin
                    next_state.ovf2_irq_enable = wbyte[LTIM_CTRL2_OVF2_IE];
                end
                LTIM_IDX_RELOAD: begin
                    next_state.reload = wbyte;
                end
                LTIM_IDX_CTRL1: begin
                    next_state.cap_irq_enable  = wbyte[LTIM_CTRL1_CAP_IE];
                    next_state.period_double   = wbyte[LTIM_CTRL1_PERIOD];
                    next_state.ovf1_irq_enable = wbyte[LTIM_CTRL1_OVF1_IE];
                end
                LTIM_IDX_IRQ_MASK: begin
                    next_state.irq_mask = wbyte[LTIM_IRQ_W-1:0];
                end
                default: begin
                    next_state.irq_mask = next_state.irq_mask;
                end
            endcase
        end

        // Capture pin synchroniser and edge history.
        next_state.pin_meta = capture_pin;
        next_state.pin_sync = cur.pin_meta;
        next_state.pin_prev = cur.pin_sync;

        // Read data is loaded in the setup cycle; refused addresses read as zero.
        if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            next_state.prdata = {LTIM_RDATA_PAD, (hit ? rbyte : LTIM_BYTE_ZERO)};
        end
    end

    // State register; the capture flag, though undefined in silicon, resets clear here.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= LTIM_STATE_RST;
        end else begin
            cur <= next_state;
        end
    end

    // Outputs. Zero wait states keep every transfer to one access cycle.
    assign prdata              = cur.prdata;
    assign pready              = 1'b1;
    assign pslverr             = access && !hit;
    assign irq_first_overflow  = cur.ovf1_flag && cur.ovf1_irq_enable;
    assign irq_second_overflow = cur.ovf2_flag && cur.ovf2_irq_enable;
    assign irq_capture         = cur.cap_flag && cur.cap_irq_enable;
    assign irq                 = |(cur.irq_status & cur.irq_mask);

    // Checks run on the block's single clock and are idle under reset.
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence seq_ctrl2_read;
        rd && (idx == LTIM_IDX_CTRL2);
    endsequence

    sequence seq_capture_taken;
        cap_ev ##1 cur.cap_flag;
    endsequence

    // Thirty-one quiet cycles that must follow every tick.
    sequence seq_no_tick_31;
        !tick [*8] ##1 !tick [*8] ##1 !tick [*8] ##1 !tick [*7];
    endsequence

    // Thirty-two running cycles; a halt anywhere in them delays the next tick instead.
    sequence seq_run_32;
        !halt_mode [*8] ##1 !halt_mode [*8] ##1 !halt_mode [*8] ##1 !halt_mode [*8];
    endsequence

    // Second counter and its flag.
    chk_ovf2_flag_set: assert property (ovf2_ev |=> cur.ovf2_flag)
        else $error("Second overflow did not set its flag.");

    chk_ovf2_read_clear: assert property (
            seq_ctrl2_read ##0 !ovf2_ev |=> !cur.ovf2_flag)
        else $error("Reading the second control register did not clear its flag.");

    chk_ovf2_flag_ro: assert property (
            wr && (idx == LTIM_IDX_CTRL2) && !ovf2_ev && !cur.ovf2_flag |=> !cur.ovf2_flag)
        else $error("A write set the second overflow flag.");

    chk_set_wins_clear: assert property (
            seq_ctrl2_read ##0 ovf2_ev |=> cur.ovf2_flag)
        else $error("Overflow was lost against a clearing read.");

    chk_cnt2_reload: assert property (ovf2_ev |=> cur.count2 == $past(cur.reload))
        else $error("Counter2 did not take the reload value at overflow.");

    chk_cnt2_step: assert property (
            tick && !ovf2_ev |=> cur.count2 == $past(cur.count2) + 8'h01)
        else $error("Counter2 did not advance by one on a tick.");

    // Shared prescaler, first counter and halt.
    chk_cnt1_wrap: assert property (
            ovf1_wrap |=> cur.count1 == 8'h00 ##1 (cur.count1 == 8'h00) [*8])
        else $error("Counter1 did not wrap to zero and hold until the next tick.");

    chk_tick_spacing: assert property (tick |=> seq_no_tick_31)
        else $error("Counters advanced more often than once every 32 cycles.");

    chk_tick_period: assert property (tick ##1 seq_run_32 |-> tick)
        else $error("Counters did not advance 32 running cycles after a tick.");

    chk_halt_freeze: assert property (
            halt_mode |=> $stable(cur.count2) && $stable(cur.count1))
        else $error("A counter moved during halt.");

    chk_ovf1_flag_set: assert property (ovf1_ev |=> cur.ovf1_flag)
        else $error("First overflow did not set its flag.");

    chk_ovf1_read_clear: assert property (
            rd && (idx == LTIM_IDX_CTRL1) && !ovf1_ev |=> !cur.ovf1_flag)
        else $error("Reading the first control register did not clear its flag.");

    // Input capture and its flag, and the doubled first period.
    chk_capture_latch: assert property (cap_ev |=> cur.capture == $past(cur.count1))
        else $error("Capture did not latch counter1.");

    chk_capture_hold: assert property (
            seq_capture_taken ##0 !rd [*8] |-> $stable(cur.capture))
        else $error("Capture value changed while its flag was set.");

    chk_cap_read_clear: assert property (
            rd && (idx == LTIM_IDX_CAPTURE) && !cap_ev |=> !cur.cap_flag)
        else $error("Reading the capture register did not clear the capture flag.");

    chk_cap_blocked: assert property (
            cur.cap_flag && !(rd && (idx == LTIM_IDX_CAPTURE)) |=> $stable(cur.capture))
        else $error("A capture happened while the capture flag was set.");

    chk_period_double: assert property (
            ovf1_ev && cur.period_double && !wr |=> !ovf1_ev [*8])
        else $error("Doubled period produced overflows too close together.");

    // Interrupt requests and the sticky status.
    chk_irq2_request: assert property (
            ovf2_ev && cur.ovf2_irq_enable && !wr |=> irq_second_overflow)
        else $error("Enabled second overflow raised no request.");

    chk_irq1_request: assert property (
            ovf1_ev && cur.ovf1_irq_enable && !wr |=> irq_first_overflow)
        else $error("Enabled first overflow raised no request.");

    chk_irq_cap_request: assert property (
            cap_ev && cur.cap_irq_enable && !wr |=> irq_capture)
        else $error("Enabled capture raised no request.");

    chk_status_read_clear: assert property (
            rd && (idx == LTIM_IDX_IRQ_STATUS) && (events == '0) |=> cur.irq_status == '0)
        else $error("Reading the interrupt status did not clear it.");

    // Read data of the first control register.
    chk_ctrl1_reserved: assert property (
            apb_req.psel && !apb_req.penable && !apb_req.pwrite && (idx == LTIM_IDX_CTRL1)
            |=> prdata[2:0] == 3'h0)
        else $error("Reserved bits of the first control register read nonzero.");

endmodule

// *** tb_ltim_top.sv ***
// Self-checking testbench for the dual timebase timer with input capture.
`timescale 1ns/100ps
module tb_ltim_top
    import ltim_pkg::*;
;
    `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

    logic             sys_clk;
    logic             rstn;
    logic             halt_mode;
    logic             capture_pin;
    ltim_apb_req_type apb_req;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq_first_overflow;
    logic             irq_second_overflow;
    logic             irq_capture;
    logic             irq;
    logic [3:0]       irqs;
    logic [31:0]      rd;
    logic             err;
    int               errors = 0;
    int               checked = 0;
    int               cyc = 0;
    int               act = 0;

    ltim_top ltim_top_i (
        .sys_clk             (sys_clk),
        .rstn                (rstn),
        .apb_req             (apb_req),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .halt_mode           (halt_mode),
        .capture_pin         (capture_pin),
        .irq_first_overflow  (irq_first_overflow),
        .irq_second_overflow (irq_second_overflow),
        .irq_capture         (irq_capture),
        .irq                 (irq)
    );

    // Interrupt outputs gathered so one wait task can watch any of them.
    assign irqs = {irq, irq_capture, irq_second_overflow, irq_first_overflow};

    // Free-running clock of 100 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Cycle counters; act counts only edges on which the prescaler may advance.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (rstn && !halt_mode) begin
            act <= act + 1;
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high at a rising edge.
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d);
        @(posedge sys_clk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= w;
        apb_req.paddr   <= {idx, 2'b00};
        apb_req.pwdata  <= d;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // Waits on the falling edge so registered outputs have settled; a miss ends the run.
    task automatic wait_irq(input int k, input int lim, output int t);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (irqs[k] !== 1'b1 && n < lim);
        if (n >= lim) begin
            errors++;
            $display("CHECK FAILED interrupt %0d expected 1 seen 0", k);
            stop_test();
        end
        t = cyc;
    endtask

    // Watchdog sized well above the longest expected run of about 50000 cycles.
    initial begin
        repeat (80000) @(posedge sys_clk);
        errors++;
        $display("CHECK FAILED watchdog expected done seen hang");
        stop_test();
    end

    // Main sequence of tests.
    initial begin
        logic [7:0]  r;
        logic [7:0]  e;
        int          t1;
        int          t2;
        int          h;
        logic [5:0]  bad [3];
        rstn = 1'b0;
        halt_mode = 1'b0;
        capture_pin = 1'b0;
        apb_req = '0;
        bad = '{6'h00, 6'h0F, 6'h3F};
        void'($urandom(98477));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        // Reset values, access kinds and unmapped words.
        xfer(1'b0, LTIM_IDX_CAPTURE, 32'h0); `CHK("capture reset", 32'h0, rd)
        xfer(1'b0, LTIM_IDX_CTRL2, 32'h0); `CHK("ctrl2 reset", 32'h0, rd)
        xfer(1'b0, LTIM_IDX_RELOAD, 32'h0); `CHK("reload reset", 32'h0, rd)
        xfer(1'b0, LTIM_IDX_CTRL1, 32'h0); `CHK("ctrl1 reset", 32'h0, rd)
        xfer(1'b0, LTIM_IDX_IRQ_MASK, 32'h0); `CHK("mask reset", 32'h0, rd)
        foreach (bad[i]) begin
            xfer(1'b0, bad[i], 32'h0);
            `CHK("unmapped error", 1'b1, err)
            `CHK("unmapped data", 32'h0, rd)
        end
        xfer(1'b1, LTIM_IDX_CTRL1, 32'hFF);
        xfer(1'b0, LTIM_IDX_CTRL1, 32'h0);
        `CHK("ctrl1 ro bits", 32'hB0, rd)
        xfer(1'b1, LTIM_IDX_CTRL1, 32'h0);
        xfer(1'b1, LTIM_IDX_CTRL2, 32'h3);
        xfer(1'b0, LTIM_IDX_CTRL2, 32'h0); `CHK("ctrl2 flag ro", 32'h2, rd)
        $display("test registers done");
        // Second counter: random reload near the top so overflows come quickly.
        r = 8'hF0 + 8'($urandom_range(14, 0));
        xfer(1'b1, LTIM_IDX_RELOAD, {24'hFFFFFF, r});
        xfer(1'b0, LTIM_IDX_RELOAD, 32'h0); `CHK("reload rw", {24'h0, r}, rd)
        wait_irq(1, 9000, t1);
        xfer(1'b0, LTIM_IDX_COUNT2, 32'h0); `CHK("count after wrap", {24'h0, r}, rd)
        xfer(1'b0, LTIM_IDX_CTRL2, 32'h0); `CHK("ctrl2 flag set", 32'h3, rd)
        xfer(1'b0, LTIM_IDX_CTRL2, 32'h0); `CHK("ctrl2 read clear", 32'h2, rd)
        `CHK("second irq low", 1'b0, irq_second_overflow)
        xfer(1'b1, LTIM_IDX_CTRL2, 32'h0);
        repeat (600) @(posedge sys_clk);
        `CHK("second irq masked", 1'b0, irq_second_overflow)
        xfer(1'b0, LTIM_IDX_CTRL2, 32'h0); `CHK("flag without enable", 32'h1, rd)
        $display("test second counter done");
        // First timebase period, stretched by a random halt span.
        xfer(1'b0, LTIM_IDX_IRQ_STATUS, 32'h0);
        xfer(1'b1, LTIM_IDX_IRQ_MASK, 32'h1);
        // The wrap near cycle 8000 left the flag set; clear it so t1 marks a real event.
        xfer(1'b0, LTIM_IDX_CTRL1, 32'h0); `CHK("first flag stale", 32'h8, rd)
        xfer(1'b1, LTIM_IDX_CTRL1, 32'h10);
        wait_irq(0, 9000, t1);
        `CHK("irq unmasked", 1'b1, irq)
        xfer(1'b0, LTIM_IDX_CTRL1, 32'h0); `CHK("first flag", 32'h18, rd)
        xfer(1'b0, LTIM_IDX_CTRL1, 32'h0); `CHK("first clear", 32'h10, rd)
        xfer(1'b0, LTIM_IDX_IRQ_STATUS, 32'h0); `CHK("status ovf1", 32'h1, rd & 32'h1)
        xfer(1'b1, LTIM_IDX_IRQ_MASK, 32'h0);
        `CHK("irq after clear", 1'b0, irq)
        h = 50 + $urandom_range(200, 0);
        @(posedge sys_clk);
        halt_mode <= 1'b1;
        repeat (h) @(posedge sys_clk);
        halt_mode <= 1'b0;
        wait_irq(0, 9000, t2);
        `CHK("period with halt", 8000 + h, t2 - t1)
        `CHK("irq masked", 1'b0, irq)
        // Doubled period measured between two consecutive events.
        xfer(1'b1, LTIM_IDX_CTRL1, 32'h30);
        xfer(1'b0, LTIM_IDX_CTRL1, 32'h0);
        wait_irq(0, 25000, t1);
        xfer(1'b0, LTIM_IDX_CTRL1, 32'h0);
        wait_irq(0, 17000, t2);
        `CHK("doubled period", 16000, t2 - t1)
        $display("test first timebase done");
        // Capture in mid-tick so the synchroniser delay cannot cross a count change.
        xfer(1'b0, LTIM_IDX_CAPTURE, 32'h0);
        xfer(1'b1, LTIM_IDX_CTRL1, 32'h80);
        repeat ($urandom_range(300, 0)) @(posedge sys_clk);
        do @(negedge sys_clk); while (act % 32 != 8);
        e = 8'((act / 32) % 250);
        @(posedge sys_clk);
        capture_pin <= ~capture_pin;
        wait_irq(2, 20, t1);
        `CHK("capture irq", 1'b1, irq_capture)
        repeat (40) @(posedge sys_clk);
        capture_pin <= ~capture_pin;
        repeat (10) @(posedge sys_clk);
        xfer(1'b0, LTIM_IDX_CTRL1, 32'h0); `CHK("capture flag", 32'hC0, rd & 32'hF7)
        xfer(1'b0, LTIM_IDX_CAPTURE, 32'h0);
        `CHK("capture value", {24'h0, e}, rd)
        xfer(1'b0, LTIM_IDX_CTRL1, 32'h0); `CHK("capture cleared", 32'h80, rd & 32'hF7)
        `CHK("capture irq low", 1'b0, irq_capture)
        $display("test capture done");
        stop_test();
    end
endmodule
